// ==== src/pasc_pkg.sv ====
package pasc_pkg;

  // register width and avalon address width (byte addressing)
  localparam int unsigned REG_W   = 8;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_MODE_CTRL  = 8'h15; // output_polarity_select, module enable
  localparam logic [ADDR_W-1:0] IDX_PWM_CONFIG = 8'h16; // auto_restart_enable
  localparam logic [ADDR_W-1:0] IDX_ASC        = 8'h17; // auto_shutdown_control
  localparam logic [ADDR_W-1:0] IDX_PIN_EN     = 8'h18; // pin output enables
  localparam logic [ADDR_W-1:0] IDX_STATUS     = 8'h19; // period_timer_flag, live cause
  localparam logic [ADDR_W-1:0] IDX_PERIOD     = 8'h1a; // period_timer period
  localparam logic [ADDR_W-1:0] IDX_DUTY       = 8'h1b; // duty count

  // auto_shutdown_control fields
  localparam int unsigned ASC_FLAG_BIT = 7;  // shutdown_event_flag
  localparam int unsigned ASC_SEL_MSB  = 6;  // shutdown_source_select
  localparam int unsigned ASC_SEL_LSB  = 4;
  localparam int unsigned ASC_AC_MSB   = 3;  // pair_ac_shutdown_level
  localparam int unsigned ASC_AC_LSB   = 2;
  localparam int unsigned ASC_BD_MSB   = 1;  // pair_bd_shutdown_level
  localparam int unsigned ASC_BD_LSB   = 0;

  // pwm_config_register fields
  localparam int unsigned CFG_RESTART_BIT = 7;

  // mode control fields
  localparam int unsigned MODE_POL_AC_BIT = 0;
  localparam int unsigned MODE_POL_BD_BIT = 1;
  localparam int unsigned MODE_EN_BIT     = 2;

  // status fields
  localparam int unsigned STAT_PTF_BIT   = 0;
  localparam int unsigned STAT_CAUSE_BIT = 1;

  // source select codes
  localparam logic [2:0] SRC_OFF      = 3'h0;
  localparam logic [2:0] SRC_CMP1     = 3'h1;
  localparam logic [2:0] SRC_CMP2     = 3'h2;
  localparam logic [2:0] SRC_CMP_ANY  = 3'h3;
  localparam logic [2:0] SRC_PIN      = 3'h4;
  localparam logic [2:0] SRC_PIN_CMP1 = 3'h5;
  localparam logic [2:0] SRC_PIN_CMP2 = 3'h6;
  localparam logic [2:0] SRC_ALL      = 3'h7;

  // reset values
  localparam logic [REG_W-1:0] RST_REG = 8'h00;

  // shutdown level codes (bit 1 set means tri-state)
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam int unsigned LVL_TRI_BIT = 1;

endpackage : pasc_pkg

// ==== src/pasc_src_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
module pasc_src_decode
  import pasc_pkg::*;
(
  input  wire logic [2:0] sel,       // shutdown_source_select
  input  wire logic       cmp1,      // comparator 1 tripped (high)
  input  wire logic       cmp2,      // comparator 2 tripped (high)
  input  wire logic       int_pin_b, // interrupt pin, low means shutdown
  output var  logic       cause      // selected cause present (level)
);

  // arm mask {pin, cmp2, cmp1} per select code
  function automatic logic [2:0] arm_mask(input logic [2:0] s);
    logic [2:0] m;
    m = 3'h0;
    unique case (s)
      SRC_OFF:      m = 3'h0;
      SRC_CMP1:     m = 3'h1;
      SRC_CMP2:     m = 3'h2;
      SRC_CMP_ANY:  m = 3'h3;
      SRC_PIN:      m = 3'h4;
      SRC_PIN_CMP1: m = 3'h5;
      SRC_PIN_CMP2: m = 3'h6;
      SRC_ALL:      m = 3'h7;
    endcase
    return m;
  endfunction : arm_mask

  assign cause = |(arm_mask(sel) & {~int_pin_b, cmp2, cmp1});

endmodule : pasc_src_decode
`default_nettype wire

// ==== src/pasc_pair_drive.sv ====
`timescale 1ns/1ps
`default_nettype none
module pasc_pair_drive
  import pasc_pkg::*;
(
  input  wire logic       pwm_act,   // pair is logically active
  input  wire logic       pol_low,   // 1 = active-low output
  input  wire logic       shut,      // shutdown in force
  input  wire logic [1:0] level,     // shutdown level code
  input  wire logic [1:0] pin_en,    // output enables of the two pins
  output var  logic [1:0] pin_out,   // pin output values
  output var  logic [1:0] pin_oe     // pin drive enables
);

  wire logic run_lvl;  // normal pwm level after polarity
  wire logic tri_lvl;  // shutdown asks for tri-state

  assign run_lvl = pwm_act ^ pol_low;
  assign tri_lvl = level[LVL_TRI_BIT];

  assign pin_out = shut ? (tri_lvl ? 2'b00 : {2{level[0]}}) : {2{run_lvl}};
  assign pin_oe  = (shut && tri_lvl) ? 2'b00 : pin_en;

endmodule : pasc_pair_drive
`default_nettype wire

// ==== src/pasc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module pasc_top
  import pasc_pkg::*;
(
  input  wire logic              clk_sys,          // instruction clock, 250 MHz
  input  wire logic              rst_b,            // async reset, active low
  input  wire logic [ADDR_W-1:0] avs_address,      // byte address
  input  wire logic              avs_read,         // read request
  input  wire logic              avs_write,        // write request
  input  wire logic [DATA_W-1:0] avs_writedata,    // write data
  output var  logic [DATA_W-1:0] avs_readdata,     // read data
  output var  logic              avs_waitrequest,  // stall, low for one cycle to answer
  input  wire logic              cmp1_out,         // comparator 1 output
  input  wire logic              cmp2_out,         // comparator 2 output
  input  wire logic              int_pin_b,        // interrupt pin, active low
  input  wire logic              sleep,            // device asleep, clocks stopped
  output var  logic              output_a,         // pin a value
  output var  logic              output_b,         // pin b value
  output var  logic              output_c,         // pin c value
  output var  logic              output_d,         // pin d value
  output var  logic              output_a_oe,      // pin a drive enable
  output var  logic              output_b_oe,      // pin b drive enable
  output var  logic              output_c_oe,      // pin c drive enable
  output var  logic              output_d_oe       // pin d drive enable
);

  // register state
  logic [REG_W-1:0] asc_ff;        // auto_shutdown_control, bit 7 is the flag
  logic [REG_W-1:0] cfg_ff;        // pwm_config_register
  logic [REG_W-1:0] mode_ff;       // pwm_mode_control_register subset
  logic [3:0]       pin_en_ff;     // output enables {d,c,b,a}
  logic [REG_W-1:0] period_ff;     // period match value
  logic [REG_W-1:0] duty_ff;       // duty count
  logic [REG_W-1:0] count_ff;      // period_timer counter
  logic             ptf_ff;        // period_timer_flag
  logic             hold_ff;       // shutdown held until period boundary
  logic [DATA_W-1:0] rdata_ff;     // read data register
  logic             wait_ff;       // waitrequest register

  // next values
  logic [REG_W-1:0] nxt_asc;
  logic [REG_W-1:0] nxt_count;
  logic             nxt_ptf;
  logic             nxt_hold;

  // bus decode
  wire logic        req;           // read or write pending
  wire logic        ack;           // request taken this edge
  wire logic        wr;            // write taken this edge
  wire logic [ADDR_W-1:0] widx;    // word index
  wire logic        hit_mode;
  wire logic        hit_cfg;
  wire logic        hit_asc;
  wire logic        hit_pin;
  wire logic        hit_stat;
  wire logic        hit_per;
  wire logic        hit_duty;
  wire logic [REG_W-1:0] wbyte;    // low write byte
  logic [REG_W-1:0] rd_mux;        // read selection

  // block signals
  wire logic        cause_raw;     // decoded cause from pins
  wire logic        cause;         // cause seen by the block
  wire logic        flag;          // shutdown_event_flag
  wire logic        restart_en;    // auto_restart_enable
  wire logic        mod_en;        // module enable
  wire logic        period_start;  // counter wraps, new period begins
  wire logic        pwm_act;       // modulated level
  wire logic        shut;          // shutdown applied to pins
  wire logic [1:0]  ac_out;
  wire logic [1:0]  ac_oe;
  wire logic [1:0]  bd_out;
  wire logic [1:0]  bd_oe;

  // word-aligned decode; low two address bits ignored
  assign widx     = {2'b00, avs_address[ADDR_W-1:2]};
  assign hit_mode = (widx == IDX_MODE_CTRL);
  assign hit_cfg  = (widx == IDX_PWM_CONFIG);
  assign hit_asc  = (widx == IDX_ASC);
  assign hit_pin  = (widx == IDX_PIN_EN);
  assign hit_stat = (widx == IDX_STATUS);
  assign hit_per  = (widx == IDX_PERIOD);
  assign hit_duty = (widx == IDX_DUTY);
  assign wbyte    = avs_writedata[REG_W-1:0];
  assign req      = avs_read || avs_write;
  // bus stalls in sleep so nothing changes
  assign ack      = req && !wait_ff && !sleep;
  assign wr       = ack && avs_write;

  assign flag       = asc_ff[ASC_FLAG_BIT];
  // restart enable from config bit 7
  assign restart_en = cfg_ff[CFG_RESTART_BIT];
  assign mod_en     = mode_ff[MODE_EN_BIT];

  // cause decoder
  pasc_src_decode u_src (
    .sel       (asc_ff[ASC_SEL_MSB:ASC_SEL_LSB]),
    .cmp1      (cmp1_out),
    .cmp2      (cmp2_out),
    .int_pin_b (int_pin_b),
    .cause     (cause_raw)
  );

  // cause masked in sleep so pins keep their level
  assign cause = cause_raw && !sleep;

  // pins forced without waiting for an edge
  assign shut = flag || cause || hold_ff;

  // period timer
  assign period_start = mod_en && (count_ff == period_ff);
  assign pwm_act      = mod_en && (count_ff < duty_ff);

  // read mux; unmapped reads return zero
  always_comb begin
    rd_mux = RST_REG;
    if (hit_mode) begin
      rd_mux = mode_ff;
    end else if (hit_cfg) begin
      rd_mux = cfg_ff;
    end else if (hit_asc) begin
      rd_mux = asc_ff;
    end else if (hit_pin) begin
      rd_mux = {4'h0, pin_en_ff};
    end else if (hit_stat) begin
      rd_mux = {6'h00, cause, ptf_ff};
    end else if (hit_per) begin
      rd_mux = period_ff;
    end else if (hit_duty) begin
      rd_mux = duty_ff;
    end
  end

  // shutdown control register next value
  always_comb begin
    nxt_asc = asc_ff;
    if (wr && hit_asc) begin
      nxt_asc = wbyte;
      // a clear is dropped while a cause is active
      if (cause) begin
        nxt_asc[ASC_FLAG_BIT] = 1'b1;
      end
    end else if (cause) begin
      // flag held while the level persists
      nxt_asc[ASC_FLAG_BIT] = 1'b1;
    end else if (restart_en && flag) begin
      // auto restart clears once cause is gone
      nxt_asc[ASC_FLAG_BIT] = 1'b0;
    end
    // without restart only a write clears it
    // a written one sets the flag like an event
    // frozen in sleep, kept for wake
    if (sleep) begin
      nxt_asc = asc_ff;
    end
  end

  // timer, period flag and restart hold next values
  always_comb begin
    nxt_count = count_ff;
    nxt_ptf   = ptf_ff;
    nxt_hold  = hold_ff;
    if (!sleep) begin
      if (!mod_en || period_start) begin
        nxt_count = RST_REG;
      end else begin
        nxt_count = count_ff + 8'h01;
      end
      // software clears with a one; a new period wins
      if (wr && hit_stat && wbyte[STAT_PTF_BIT]) begin
        nxt_ptf = 1'b0;
      end
      // set at each wrap, the first being period two
      if (period_start) begin
        nxt_ptf = 1'b1;
      end
      // shutdown held until a period boundary
      nxt_hold = flag || cause || (hold_ff && !period_start);
    end
  end

  // shutdown control and timer registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      asc_ff   <= RST_REG;
      count_ff <= RST_REG;
      ptf_ff   <= 1'b0;
      hold_ff  <= 1'b0;
    end else begin
      asc_ff   <= nxt_asc;
      count_ff <= nxt_count;
      ptf_ff   <= nxt_ptf;
      hold_ff  <= nxt_hold;
    end
  end

  // plain configuration registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff    <= RST_REG;
      mode_ff   <= RST_REG;
      pin_en_ff <= 4'h0;
      period_ff <= RST_REG;
      duty_ff   <= RST_REG;
    end else if (wr) begin
      if (hit_cfg)  cfg_ff    <= wbyte;
      if (hit_mode) mode_ff   <= wbyte;
      if (hit_pin)  pin_en_ff <= wbyte[3:0];
      if (hit_per)  period_ff <= wbyte;
      if (hit_duty) duty_ff   <= wbyte;
    end
  end

  // avalon answer: one wait cycle, then waitrequest low for one edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff <= !(req && wait_ff && !sleep);
      if (req && wait_ff && !sleep) begin
        rdata_ff <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
      end
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  // pair a/c modulated, pair b/d complementary
  pasc_pair_drive u_ac (
    .pwm_act (pwm_act),
    .pol_low (mode_ff[MODE_POL_AC_BIT]),
    .shut    (shut),
    .level   (asc_ff[ASC_AC_MSB:ASC_AC_LSB]),
    .pin_en  ({pin_en_ff[2], pin_en_ff[0]}),
    .pin_out (ac_out),
    .pin_oe  (ac_oe)
  );

  pasc_pair_drive u_bd (
    .pwm_act (mod_en && !pwm_act),
    .pol_low (mode_ff[MODE_POL_BD_BIT]),
    .shut    (shut),
    .level   (asc_ff[ASC_BD_MSB:ASC_BD_LSB]),
    .pin_en  ({pin_en_ff[3], pin_en_ff[1]}),
    .pin_out (bd_out),
    .pin_oe  (bd_oe)
  );

  // pins are not registered: the shutdown path must act without a clock
  assign output_a    = ac_out[0];
  assign output_c    = ac_out[1];
  assign output_b    = bd_out[0];
  assign output_d    = bd_out[1];
  assign output_a_oe = ac_oe[0];
  assign output_c_oe = ac_oe[1];
  assign output_b_oe = bd_oe[0];
  assign output_d_oe = bd_oe[1];

  // checks
  property p_src_off;
    @(posedge clk_sys) disable iff (!rst_b)
      (asc_ff[ASC_SEL_MSB:ASC_SEL_LSB] == SRC_OFF) |-> !cause;
  endproperty
  a_src_off: assert property (p_src_off) else $error("cause with source off");

  property p_src_cmp1;
    @(posedge clk_sys) disable iff (!rst_b)
      (asc_ff[ASC_SEL_MSB:ASC_SEL_LSB] == SRC_CMP1 && !sleep) |-> (cause == cmp1_out);
  endproperty
  a_src_cmp1: assert property (p_src_cmp1) else $error("cmp1 select wrong");

  property p_event_sets;
    @(posedge clk_sys) disable iff (!rst_b)
      cause |-> shut ##1 flag;
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event did not set flag");

  property p_auto_clear;
    @(posedge clk_sys) disable iff (!rst_b)
      (restart_en && flag && !cause && !sleep && !(wr && hit_asc)) |=> !flag;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("auto restart missed");

  property p_manual_hold;
    @(posedge clk_sys) disable iff (!rst_b)
      (!restart_en && flag && !(wr && hit_asc)) |=> flag;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("flag cleared itself");

  property p_hold_period;
    @(posedge clk_sys) disable iff (!rst_b)
      ($fell(flag) && !period_start) |-> shut ##1 shut;
  endproperty
  a_hold_period: assert property (p_hold_period) else $error("resumed before period");

  property p_write_blocked;
    @(posedge clk_sys) disable iff (!rst_b)
      (cause && wr && hit_asc && !wbyte[ASC_FLAG_BIT]) |=> flag;
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("clear taken in cause");

  property p_force;
    @(posedge clk_sys) disable iff (!rst_b)
      (wr && hit_asc && wbyte[ASC_FLAG_BIT]) |=> (flag && shut);
  endproperty
  a_force: assert property (p_force) else $error("forced shutdown missed");

  property p_ptf;
    @(posedge clk_sys) disable iff (!rst_b)
      (period_start && !sleep) |=> (ptf_ff && count_ff == RST_REG);
  endproperty
  a_ptf: assert property (p_ptf) else $error("period flag not set");

  property p_no_drive;
    @(posedge clk_sys) disable iff (!rst_b)
      (pin_en_ff == 4'h0) |-> !(output_a_oe || output_b_oe || output_c_oe || output_d_oe);
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven while disabled");

  property p_sleep_frozen;
    @(posedge clk_sys) disable iff (!rst_b)
      sleep |=> ($stable(count_ff) && $stable(asc_ff) && $stable(output_a));
  endproperty
  a_sleep_frozen: assert property (p_sleep_frozen) else $error("state moved in sleep");

  property p_low_level;
    @(posedge clk_sys) disable iff (!rst_b)
      (shut && pin_en_ff[0] && asc_ff[ASC_AC_MSB:ASC_AC_LSB] == LVL_LOW)
        |-> (output_a_oe && !output_a);
  endproperty
  a_low_level: assert property (p_low_level) else $error("pair a/c not low");

endmodule : pasc_top
`default_nettype wire

// ==== bench/pasc_bridge_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// external half or full bridge switch drivers seen from the pins
module pasc_bridge_model (
  input  wire logic [3:0] pin_val, // pin values {d,c,b,a}
  input  wire logic [3:0] pin_oe,  // pin drive enables {d,c,b,a}
  output var  logic [3:0] pad      // level each switch driver sees
);
  // pull-downs keep the switches off while a pin floats
  always_comb begin
    pad = pin_val & pin_oe;
  end
endmodule : pasc_bridge_model
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pasc_pkg::*;
  logic              clk_sys = 1'b0; // 250 MHz
  logic              rst_b   = 1'b0; // active low reset
  logic [ADDR_W-1:0] adr     = '0;   // bus address
  logic              rd      = 1'b0; // read request
  logic              wr      = 1'b0; // write request
  logic [DATA_W-1:0] wdat    = '0;   // write data
  logic [DATA_W-1:0] rdat;           // read data
  logic              wait_q;         // waitrequest
  logic              cmp1    = 1'b0; // comparator 1
  logic              cmp2    = 1'b0; // comparator 2
  logic              int_b   = 1'b1; // interrupt pin, idle high
  logic              sleep   = 1'b0; // sleep request
  logic [3:0]        pv, po, pad;    // pin values, enables, pads
  logic [7:0]        d, snap;        // read result and snapshot
  logic [6:0]        rnd;            // random config bits
  int                err_total  = 0; // mismatches
  int                n_compared = 0; // comparisons
  int                n;              // poll counter
  always #2 clk_sys = ~clk_sys;
  pasc_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_q),
    .cmp1_out(cmp1), .cmp2_out(cmp2), .int_pin_b(int_b), .sleep(sleep),
    .output_a(pv[0]), .output_b(pv[1]), .output_c(pv[2]), .output_d(pv[3]),
    .output_a_oe(po[0]), .output_b_oe(po[1]), .output_c_oe(po[2]), .output_d_oe(po[3]));
  pasc_bridge_model bridge_u (.pin_val(pv), .pin_oe(po), .pad(pad));
  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one bus access; held until waitrequest is sampled low at a rising edge
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] v);
    int k;
    @(posedge clk_sys);
    adr  <= {idx[5:0], 2'b00};
    wdat <= {24'h00_0000, v};
    wr   <= w;
    rd   <= ~w;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (wait_q !== 1'b0 && k < 200);
    d = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 200) begin
      err_total++;
      finish_test();
    end
  endtask : acc
  // clear the period flag, then poll until the next wrap sets it
  task automatic wait_wrap();
    acc(1, IDX_STATUS, 8'h01);
    n = 0;
    do begin
      acc(0, IDX_STATUS, 8'h00);
      n++;
    end while (d[STAT_PTF_BIT] !== 1'b1 && n < 300);
    if (n >= 300) begin
      err_total++;
      finish_test();
    end
  endtask : wait_wrap
  // pad levels of a shutdown with level codes lv, all pins enabled
  function automatic logic [3:0] sd_pad(input logic [3:0] lv);
    logic a, b;
    a = ~lv[3] & lv[2];
    b = ~lv[1] & lv[0];
    return {b, a, b, a};
  endfunction : sd_pad
  // cause of each source select code
  function automatic logic f_cause(input logic [2:0] s, input logic [2:0] k);
    case (s)
      3'h1:    return k[0];
      3'h2:    return k[1];
      3'h3:    return k[0] | k[1];
      3'h4:    return k[2];
      3'h5:    return k[2] | k[0];
      3'h6:    return k[2] | k[1];
      3'h7:    return |k;
      default: return 1'b0;
    endcase
  endfunction : f_cause
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    void'($urandom(21555));
    // registers clear and pins float after reset
    for (int i = 8'h15; i <= 8'h1b; i++) begin
      acc(0, 8'(i), 8'h00);
      chk("reset reg", RST_REG, d);
    end
    acc(0, 8'h30, 8'h00);
    chk("unmapped", 8'h00, d);
    chk("reset oe", 8'h00, {4'h0, po});
    $display("test reset done");
    // polarity per pair, set while pins still float, one period wrap waited first
    acc(1, IDX_PERIOD, 8'h05);
    for (int p = 0; p < 4; p++) begin
      acc(1, IDX_MODE_CTRL, 8'(4 + p));
      wait_wrap();
      chk("period flag", 8'h01, {7'h00, d[0]});
      acc(1, IDX_PIN_EN, 8'h0f);
      chk("polarity", {4'h0, ~p[1], p[0], ~p[1], p[0]}, {4'h0, pv});
      acc(1, IDX_PIN_EN, 8'h00);
    end
    $display("test polarity done");
    // every source code against every cause mix, auto restart on
    rnd = 7'($urandom());
    acc(1, IDX_PWM_CONFIG, {1'b1, rnd});
    acc(0, IDX_PWM_CONFIG, 8'h00);
    chk("config", {1'b1, rnd}, d);
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 8; k++) begin
        acc(1, IDX_ASC, {1'b0, 3'(s), 4'h0});
        @(posedge clk_sys);
        {int_b, cmp2, cmp1} <= {~k[2], k[1], k[0]};
        acc(0, IDX_STATUS, 8'h00);
        chk("live cause", {7'h00, f_cause(3'(s), 3'(k))}, {7'h00, d[1]});
        acc(0, IDX_ASC, 8'h00);
        chk("flag set", {f_cause(3'(s), 3'(k)), 3'(s), 4'h0}, d);
        {int_b, cmp2, cmp1} <= 3'b100;
        repeat (2) @(posedge clk_sys);
        acc(0, IDX_ASC, 8'h00);
        chk("auto clear", {1'b0, 3'(s), 4'h0}, d);
      end
    end
    $display("test sources done");
    // forced shutdown levels, auto restart off
    acc(1, IDX_PWM_CONFIG, 8'h00);
    acc(1, IDX_PIN_EN, 8'h0f);
    for (int lv = 0; lv < 16; lv++) begin
      acc(1, IDX_ASC, {1'b1, SRC_OFF, 4'(lv)});
      // the write lands at this edge; let the pins settle before looking
      #1;
      chk("level pads", {4'h0, sd_pad(4'(lv))}, {4'h0, pad});
      chk("level oe", {4'h0, ~lv[1], ~lv[3], ~lv[1], ~lv[3]}, {4'h0, po});
      acc(1, IDX_ASC, {1'b0, SRC_OFF, 4'(lv)});
    end
    // pin event forces pins inside the cycle, then sticks
    acc(1, IDX_PERIOD, 8'hff);
    acc(1, IDX_ASC, {1'b0, SRC_PIN, 4'b0101});
    wait_wrap();
    @(posedge clk_sys);
    int_b <= 1'b0;
    #1;
    chk("async pads", 8'h0f, {4'h0, pad});
    acc(1, IDX_ASC, {1'b0, SRC_PIN, 4'b0101});
    acc(0, IDX_ASC, 8'h00);
    chk("write ignored", {1'b1, SRC_PIN, 4'b0101}, d);
    int_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    acc(0, IDX_ASC, 8'h00);
    chk("flag sticks", {1'b1, SRC_PIN, 4'b0101}, d);
    wait_wrap();
    acc(1, IDX_ASC, {1'b0, SRC_PIN, 4'b0101});
    acc(0, IDX_ASC, 8'h00);
    chk("fw clear", {1'b0, SRC_PIN, 4'b0101}, d);
    chk("held to wrap", 8'h0f, {4'h0, pad});
    // clear the period flag so that only the coming wrap can set it
    acc(1, IDX_STATUS, 8'h01);
    n = 0;
    while (pad === 4'hf && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 400) begin
      err_total++;
      finish_test();
    end
    acc(0, IDX_STATUS, 8'h00);
    chk("resume at wrap", 8'h01, {7'h00, d[0]});
    // both pairs active-low, zero duty: a/c idle high, b/d active low
    chk("resume pads", 8'h05, {4'h0, pad});
    $display("test shutdown done");
    // sleep freezes pins, masks causes, then carries on
    acc(1, IDX_PWM_CONFIG, 8'h80);
    acc(1, IDX_PERIOD, 8'h09);
    acc(1, IDX_DUTY, 8'(1 + $urandom_range(7)));
    repeat (5) @(posedge clk_sys);
    sleep <= 1'b1;
    @(posedge clk_sys);
    snap = {po, pv};
    int_b <= 1'b0;
    repeat (23) @(posedge clk_sys);
    chk("sleep pins", snap, {po, pv});
    int_b <= 1'b1;
    @(posedge clk_sys);
    chk("sleep frozen", snap, {po, pv});
    sleep <= 1'b0;
    acc(0, IDX_ASC, 8'h00);
    chk("wake state", {1'b0, SRC_PIN, 4'b0101}, d);
    $display("test sleep done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
